// ==== src/pabfs_params.svh ====
`ifndef PABFS_PARAMS_SVH
`define PABFS_PARAMS_SVH
// Contract
// - pa5 field 11:10 selects port/serial_clock_ch1/dma_request_ch1/ext_interrupt_1_in
// - pa4 bit 8 selects port or tx1
// - pa3 bit 6 selects port or rx1
// - pa2 field 5:4 selects port/serial_clock_ch0/dma_request_ch0/ext_interrupt_0_in
// - pa1 bit 2 selects port or tx0
// - pa0 bit 0 selects port or rx0
// - port b direction bit 1 output, 0 input
// - direction used only in port mode
// - direction bits 15:10 read zero, write zero
// - direction register resets to all zeros
// - port b control reserved bits read zero
// - pb9 field selects port/ext_interrupt_7_in/a21/converter trigger
// - pb8 field selects port/ext_interrupt_6_in/a20/bus wait
// - pb7 field selects port/ext_interrupt_5_in/a19/bus request
// - port b control registers 16-bit read/write

`define PABFS_ADDR_W 12
`define PABFS_OFS_PA_LOW_CTRL2 12'h000
`define PABFS_OFS_PB_DIR 12'h004
`define PABFS_OFS_PB_CTRL1 12'h008
`define PABFS_OFS_PB_CTRL2 12'h00C
`define PABFS_OFS_PIN_LEVEL 12'h010
`define PABFS_OFS_PIN_DRIVE 12'h014

`define PABFS_WMASK_PA_LOW_CTRL2 16'h0D75
`define PABFS_WMASK_PB_DIR 16'h03FF
`define PABFS_WMASK_PB_CTRL1 16'h0C0F
`define PABFS_WMASK_PB_CTRL2 16'hFFF5

`define PABFS_RST_PA_LOW_CTRL2 16'h0000
`define PABFS_RST_PB_DIR 16'h0000
`define PABFS_RST_PB_CTRL1 16'h0000
`define PABFS_RST_PB_CTRL2 16'h0000

`define PABFS_MODE_PORT 2'h0
`define PABFS_MODE_FN1 2'h1
`define PABFS_MODE_FN2 2'h2
`define PABFS_MODE_FN3 2'h3

`define PABFS_POS_PA5 11
`define PABFS_POS_PA4 8
`define PABFS_POS_PA3 6
`define PABFS_POS_PA2 4
`define PABFS_POS_PA1 2
`define PABFS_POS_PA0 0
`define PABFS_POS_PB9 2
`define PABFS_POS_PB8 0
`define PABFS_POS_PB7 14

`define PABFS_IDLE_LVL 4'hF
`endif

// ==== src/pabfs_pkg.sv ====
package pabfs_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pabfs_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pabfs_apb_rsp_t;

   typedef struct packed {
      logic [9:0] b;
      logic [5:0] a;
   } pabfs_pad_t;

   typedef struct packed {
      logic serial_clock_ch0_out;
      logic serial_clock_ch0_oe;
      logic serial_clock_ch1_out;
      logic serial_clock_ch1_oe;
      logic serial_tx_ch0;
      logic serial_tx_ch1;
      logic addr_bit_19_out;
      logic addr_bit_20_out;
      logic addr_bit_21_out;
   } pabfs_fn_drive_t;

   typedef struct packed {
      logic serial_clock_ch0_in;
      logic serial_clock_ch1_in;
      logic serial_rx_ch0;
      logic serial_rx_ch1;
      logic dma_request_ch0;
      logic dma_request_ch1;
      logic ext_interrupt_0_in;
      logic ext_interrupt_1_in;
      logic ext_interrupt_5_in;
      logic ext_interrupt_6_in;
      logic ext_interrupt_7_in;
      logic converter_trigger_in;
      logic bus_wait_in;
      logic bus_request_in;
   } pabfs_fn_sense_t;

   typedef enum logic [1:0] {
      PABFS_APB_IDLE = 2'h1,
      PABFS_APB_RESP = 2'h2
   } pabfs_apb_st_t;

   typedef struct packed {
      pabfs_apb_st_t apb;
      logic [15:0] pa_low_ctrl2;
      logic [15:0] pb_dir;
      logic [15:0] pb_ctrl1;
      logic [15:0] pb_ctrl2;
      pabfs_apb_rsp_t rsp;
      pabfs_pad_t pin_out;
      pabfs_pad_t pin_oe;
      pabfs_pad_t port_pin_val;
      pabfs_fn_sense_t sense;
   } pabfs_state_t;
endpackage

// ==== src/pabfs_reg_wr.sv ====
`timescale 1ns/100ps
module pabfs_reg_wr #(
   parameter logic [15:0] WMASK = 16'hFFFF
) (
   input wire logic we,
   input wire logic [15:0] cur,
   input wire logic [15:0] wdata,
   output logic [15:0] nxt
);
   // Masked bits never store, so reserved bits always read back zero
   assign nxt = we ? (wdata & WMASK) : cur;
endmodule // pabfs_reg_wr

// ==== src/pabfs_pin_cell.sv ====
`timescale 1ns/100ps
`include "pabfs_params.svh"
module pabfs_pin_cell (
   input wire logic [1:0] mode,
   input wire logic port_dir,
   input wire logic port_out,
   input wire logic [3:0] fn_out,
   input wire logic [3:0] fn_oe,
   input wire logic [3:0] idle_lvl,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   output logic [3:0] fn_in
);
   always_comb begin
      if (mode == `PABFS_MODE_PORT) begin
         pin_out = port_out;
         pin_oe = port_dir;
      end else begin
         pin_out = fn_out[mode];
         pin_oe = fn_oe[mode];
      end
      for (int k = 0; k < 4; k++) begin
         fn_in[k] = (mode == k[1:0]) ? pin_in : idle_lvl[k];
      end
      fn_in[0] = pin_in;
   end
endmodule // pabfs_pin_cell

// ==== src/pabfs_top.sv ====
`timescale 1ns/100ps
`include "pabfs_params.svh"
module pabfs_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire pabfs_pkg::pabfs_apb_req_t apb_req,
   output pabfs_pkg::pabfs_apb_rsp_t apb_rsp,
   input wire pabfs_pkg::pabfs_pad_t pin_in,
   output pabfs_pkg::pabfs_pad_t pin_out,
   output pabfs_pkg::pabfs_pad_t pin_oe,
   input wire logic [5:0] port_a_data,
   input wire logic [5:0] port_a_dir,
   input wire logic [9:0] port_b_data,
   output pabfs_pkg::pabfs_pad_t port_pin_val,
   input wire pabfs_pkg::pabfs_fn_drive_t fn_drive,
   output pabfs_pkg::pabfs_fn_sense_t fn_sense
);
   import pabfs_pkg::*;

   localparam pabfs_state_t STATE_RST = '{
      apb: PABFS_APB_IDLE,
      pa_low_ctrl2: `PABFS_RST_PA_LOW_CTRL2,
      pb_dir: `PABFS_RST_PB_DIR,
      pb_ctrl1: `PABFS_RST_PB_CTRL1,
      pb_ctrl2: `PABFS_RST_PB_CTRL2,
      rsp: '0,
      pin_out: '0,
      pin_oe: '0,
      port_pin_val: '0,
      sense: '1
   };

   pabfs_state_t state_reg;
   pabfs_state_t state_next;

   logic access;
   logic hit;
   logic commit;
   logic we_pa;
   logic we_dir;
   logic we_cr1;
   logic we_cr2;
   logic [15:0] pa_nxt;
   logic [15:0] dir_nxt;
   logic [15:0] cr1_nxt;
   logic [15:0] cr2_nxt;
   logic [15:0] rd_val;

   logic [1:0] pmode [0:15];
   logic [3:0] fo [0:15];
   logic [3:0] foe [0:15];
   logic [3:0] fin [0:15];
   logic pdir [0:15];
   logic pout [0:15];
   logic po [0:15];
   logic poe [0:15];
   logic [15:0] pin_flat;
   logic [6:0] pb_low_port;

   assign pin_flat = {pin_in.b, pin_in.a};
   assign access = apb_req.psel & apb_req.penable;

   always_comb begin
      hit = 1'h1;
      rd_val = 16'h0000;
      case (apb_req.paddr)
         `PABFS_OFS_PA_LOW_CTRL2: rd_val = state_reg.pa_low_ctrl2;
         `PABFS_OFS_PB_DIR: rd_val = state_reg.pb_dir;
         `PABFS_OFS_PB_CTRL1: rd_val = state_reg.pb_ctrl1;
         `PABFS_OFS_PB_CTRL2: rd_val = state_reg.pb_ctrl2;
         `PABFS_OFS_PIN_LEVEL: rd_val = state_reg.port_pin_val;
         `PABFS_OFS_PIN_DRIVE: rd_val = state_reg.pin_oe;
         default: hit = 1'h0;
      endcase
   end

   // Write lands on the same edge the master samples pready
   assign commit = access & apb_req.pwrite & hit & (state_reg.apb == PABFS_APB_RESP);
   assign we_pa = commit & (apb_req.paddr == `PABFS_OFS_PA_LOW_CTRL2);
   assign we_dir = commit & (apb_req.paddr == `PABFS_OFS_PB_DIR);
   assign we_cr1 = commit & (apb_req.paddr == `PABFS_OFS_PB_CTRL1);
   assign we_cr2 = commit & (apb_req.paddr == `PABFS_OFS_PB_CTRL2);

   pabfs_reg_wr #(
      .WMASK(`PABFS_WMASK_PA_LOW_CTRL2)
   ) u_wr_pa (
      .we(we_pa),
      .cur(state_reg.pa_low_ctrl2),
      .wdata(apb_req.pwdata[15:0]),
      .nxt(pa_nxt)
   );

   pabfs_reg_wr #(
      .WMASK(`PABFS_WMASK_PB_DIR)
   ) u_wr_dir (
      .we(we_dir),
      .cur(state_reg.pb_dir),
      .wdata(apb_req.pwdata[15:0]),
      .nxt(dir_nxt)
   );

   pabfs_reg_wr #(
      .WMASK(`PABFS_WMASK_PB_CTRL1)
   ) u_wr_cr1 (
      .we(we_cr1),
      .cur(state_reg.pb_ctrl1),
      .wdata(apb_req.pwdata[15:0]),
      .nxt(cr1_nxt)
   );

   pabfs_reg_wr #(
      .WMASK(`PABFS_WMASK_PB_CTRL2)
   ) u_wr_cr2 (
      .we(we_cr2),
      .cur(state_reg.pb_ctrl2),
      .wdata(apb_req.pwdata[15:0]),
      .nxt(cr2_nxt)
   );

   // Fields for PB6..PB0 are stored but their functions live elsewhere
   always_comb begin
      pb_low_port[0] = ~cr2_nxt[0];
      pb_low_port[1] = ~cr2_nxt[2];
      pb_low_port[2] = ({cr1_nxt[10], cr2_nxt[5:4]} == 3'h0);
      pb_low_port[3] = ({cr1_nxt[11], cr2_nxt[7:6]} == 3'h0);
      pb_low_port[4] = (cr2_nxt[9:8] == 2'h0);
      pb_low_port[5] = (cr2_nxt[11:10] == 2'h0);
      pb_low_port[6] = (cr2_nxt[13:12] == 2'h0);
   end

   // Routing uses next-state fields so pins follow the write edge
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         pmode[i] = `PABFS_MODE_PORT;
         fo[i] = 4'h0;
         foe[i] = 4'h0;
      end
      for (int i = 0; i < 6; i++) begin
         pdir[i] = port_a_dir[i];
         pout[i] = port_a_data[i];
      end
      for (int j = 0; j < 10; j++) begin
         pdir[j + 6] = dir_nxt[j];
         pout[j + 6] = port_b_data[j];
      end
      pmode[0] = {1'h0, pa_nxt[`PABFS_POS_PA0]};
      pmode[1] = {1'h0, pa_nxt[`PABFS_POS_PA1]};
      fo[1][1] = fn_drive.serial_tx_ch0;
      foe[1][1] = 1'h1;
      pmode[2] = pa_nxt[`PABFS_POS_PA2 +: 2];
      fo[2][1] = fn_drive.serial_clock_ch0_out;
      foe[2][1] = fn_drive.serial_clock_ch0_oe;
      pmode[3] = {1'h0, pa_nxt[`PABFS_POS_PA3]};
      pmode[4] = {1'h0, pa_nxt[`PABFS_POS_PA4]};
      fo[4][1] = fn_drive.serial_tx_ch1;
      foe[4][1] = 1'h1;
      pmode[5] = pa_nxt[`PABFS_POS_PA5 -: 2];
      fo[5][1] = fn_drive.serial_clock_ch1_out;
      foe[5][1] = fn_drive.serial_clock_ch1_oe;
      for (int j = 0; j < 7; j++) begin
         pmode[j + 6] = pb_low_port[j] ? `PABFS_MODE_PORT : `PABFS_MODE_FN1;
      end
      pmode[13] = cr2_nxt[`PABFS_POS_PB7 +: 2];
      fo[13][2] = fn_drive.addr_bit_19_out;
      foe[13][2] = 1'h1;
      pmode[14] = cr1_nxt[`PABFS_POS_PB8 +: 2];
      fo[14][2] = fn_drive.addr_bit_20_out;
      foe[14][2] = 1'h1;
      pmode[15] = cr1_nxt[`PABFS_POS_PB9 +: 2];
      fo[15][2] = fn_drive.addr_bit_21_out;
      foe[15][2] = 1'h1;
   end

   for (genvar g = 0; g < 16; g++) begin : g_pin
      pabfs_pin_cell u_cell (
         .mode(pmode[g]),
         .port_dir(pdir[g]),
         .port_out(pout[g]),
         .fn_out(fo[g]),
         .fn_oe(foe[g]),
         .idle_lvl(`PABFS_IDLE_LVL),
         .pin_in(pin_flat[g]),
         .pin_out(po[g]),
         .pin_oe(poe[g]),
         .fn_in(fin[g])
      );
   end

   always_comb begin
      state_next = state_reg;
      state_next.pa_low_ctrl2 = pa_nxt;
      state_next.pb_dir = dir_nxt;
      state_next.pb_ctrl1 = cr1_nxt;
      state_next.pb_ctrl2 = cr2_nxt;
      // One wait state keeps pready a plain flip-flop
      case (state_reg.apb)
         PABFS_APB_IDLE: begin
            if (access) begin
               state_next.apb = PABFS_APB_RESP;
               state_next.rsp.pready = 1'h1;
               state_next.rsp.pslverr = ~hit;
               state_next.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : {16'h0000, rd_val};
            end
         end
         PABFS_APB_RESP: begin
            state_next.apb = PABFS_APB_IDLE;
            state_next.rsp = '0;
         end
         default: begin
            state_next.apb = PABFS_APB_IDLE;
            state_next.rsp = '0;
         end
      endcase
      for (int i = 0; i < 6; i++) begin
         state_next.pin_out.a[i] = po[i];
         state_next.pin_oe.a[i] = poe[i];
      end
      for (int j = 0; j < 10; j++) begin
         state_next.pin_out.b[j] = po[j + 6];
         state_next.pin_oe.b[j] = poe[j + 6];
      end
      state_next.port_pin_val = pin_in;
      state_next.sense.serial_rx_ch0 = fin[0][1];
      state_next.sense.serial_clock_ch0_in = fin[2][1];
      state_next.sense.dma_request_ch0 = fin[2][2];
      state_next.sense.ext_interrupt_0_in = fin[2][3];
      state_next.sense.serial_rx_ch1 = fin[3][1];
      state_next.sense.serial_clock_ch1_in = fin[5][1];
      state_next.sense.dma_request_ch1 = fin[5][2];
      state_next.sense.ext_interrupt_1_in = fin[5][3];
      state_next.sense.ext_interrupt_5_in = fin[13][1];
      state_next.sense.bus_request_in = fin[13][3];
      state_next.sense.ext_interrupt_6_in = fin[14][1];
      state_next.sense.bus_wait_in = fin[14][3];
      state_next.sense.ext_interrupt_7_in = fin[15][1];
      state_next.sense.converter_trigger_in = fin[15][3];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= STATE_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   assign apb_rsp = state_reg.rsp;
   assign pin_out = state_reg.pin_out;
   assign pin_oe = state_reg.pin_oe;
   assign port_pin_val = state_reg.port_pin_val;
   assign fn_sense = state_reg.sense;
endmodule // pabfs_top

// ==== verif/pabfs_asserts.sv ====
`timescale 1ns/100ps
`include "pabfs_params.svh"
module pabfs_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire pabfs_pkg::pabfs_apb_req_t apb_req,
   input wire pabfs_pkg::pabfs_apb_rsp_t apb_rsp,
   input wire pabfs_pkg::pabfs_pad_t pin_in,
   input wire pabfs_pkg::pabfs_pad_t pin_out,
   input wire pabfs_pkg::pabfs_pad_t pin_oe,
   input wire logic [5:0] port_a_data,
   input wire logic [5:0] port_a_dir,
   input wire logic [9:0] port_b_data,
   input wire pabfs_pkg::pabfs_pad_t port_pin_val,
   input wire pabfs_pkg::pabfs_fn_drive_t fn_drive,
   input wire pabfs_pkg::pabfs_fn_sense_t fn_sense
);
   import pabfs_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_ANSWER: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready
      |=> apb_rsp.pready) else $error("access phase not answered");
   AST_PULSE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready longer than one cycle");
   AST_NO_SPURIOUS: assert property (apb_rsp.pready
      |-> $past(apb_req.psel && apb_req.penable)) else $error("pready without access");
   AST_ERR_WITH_READY: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
      else $error("pslverr without pready");
   AST_DIR_RSV: assert property (apb_rsp.pready && !apb_req.pwrite
      && apb_req.paddr == `PABFS_OFS_PB_DIR |-> apb_rsp.prdata[31:10] == 22'h0)
      else $error("direction reserved bits not zero");
   AST_CTRL1_RSV: assert property (apb_rsp.pready && !apb_req.pwrite
      && apb_req.paddr == `PABFS_OFS_PB_CTRL1
      |-> (apb_rsp.prdata & ~{16'h0000, `PABFS_WMASK_PB_CTRL1}) == 32'h0)
      else $error("control 1 reserved bits not zero");
   AST_RST_DIR: assert property ($rose(presetn) |=> pin_oe.b == 10'h000)
      else $error("port b driven after reset");
   AST_RX0_IDLE: assert property (!fn_sense.serial_rx_ch0
      |-> $past(pin_in.a[0]) == 1'b0) else $error("receive 0 low without pin");
   AST_PA2_ONE: assert property (!fn_sense.dma_request_ch0
      |-> fn_sense.serial_clock_ch0_in && fn_sense.ext_interrupt_0_in)
      else $error("pin a2 routed twice");
   AST_PA3_OE: assert property (pin_oe.a[3] |-> $past(port_a_dir[3]))
      else $error("pin a3 driven without direction");
   AST_PB8_WAIT: assert property (!fn_sense.bus_wait_in
      |-> fn_sense.ext_interrupt_6_in && $past(pin_in.b[8]) == 1'b0)
      else $error("bus wait routing wrong");
endmodule // pabfs_asserts
bind pabfs_top pabfs_asserts u_chk (.pclk, .presetn, .apb_req, .apb_rsp, .pin_in,
   .pin_out, .pin_oe, .port_a_data, .port_a_dir, .port_b_data, .port_pin_val,
   .fn_drive, .fn_sense);

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
`include "pabfs_params.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
   import pabfs_pkg::*;
   typedef struct packed {logic rd; logic err; logic [31:0] d;} pabfs_note_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   pabfs_apb_req_t apb_req = '0;
   pabfs_apb_rsp_t apb_rsp;
   pabfs_pad_t pin_in = '0, pin_out, pin_oe, port_pin_val;
   logic [5:0] port_a_data = '0, port_a_dir = '0;
   logic [9:0] port_b_data = '0;
   pabfs_fn_drive_t fn_drive = '0;
   pabfs_fn_sense_t fn_sense;
   pabfs_note_t notes[$], nt;
   int err_total = 0;
   int n_tests = 0;
   logic [31:0] lf = 32'h4E03;
   logic [15:0] pa, dr, c1, c2;
   always #5 pclk = ~pclk;
   pabfs_top uut (.pclk, .presetn, .apb_req, .apb_rsp, .pin_in, .pin_out, .pin_oe,
      .port_a_data, .port_a_dir, .port_b_data, .port_pin_val, .fn_drive, .fn_sense);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d,
         input logic [31:0] ex, input logic er);
      int n;
      n = 0;
      notes.push_back('{!wr, er, ex});
      @(posedge pclk);
      apb_req <= '{1'b1, 1'b0, wr, a, {16'h0000, d}};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do begin @(posedge pclk); n++; end while (apb_rsp.pready !== 1'b1 && n < 20);
      if (n >= 20) err_total++;
      apb_req <= '0;
   endtask
   // Answers are matched oldest first
   always @(posedge pclk) begin
      if (apb_rsp.pready === 1'b1 && notes.size() > 0) begin
         nt = notes.pop_front();
         `CHK(apb_rsp.pslverr, nt.err)
         if (nt.rd) `CHK(apb_rsp.prdata, nt.d)
      end
   end
   task automatic chk_pins();
      pabfs_fn_sense_t s;
      logic [5:0] oa;
      logic [2:0] ob;
      logic [1:0] m2, m5, m7, m8, m9;
      m2 = pa[5:4]; m5 = pa[11:10]; m7 = c2[15:14]; m8 = c1[1:0]; m9 = c1[3:2];
      s = '1;
      if (pa[0]) s.serial_rx_ch0 = pin_in.a[0];
      if (pa[6]) s.serial_rx_ch1 = pin_in.a[3];
      if (m2 == 2'h1) s.serial_clock_ch0_in = pin_in.a[2];
      if (m2 == 2'h2) s.dma_request_ch0 = pin_in.a[2];
      if (m2 == 2'h3) s.ext_interrupt_0_in = pin_in.a[2];
      if (m5 == 2'h1) s.serial_clock_ch1_in = pin_in.a[5];
      if (m5 == 2'h2) s.dma_request_ch1 = pin_in.a[5];
      if (m5 == 2'h3) s.ext_interrupt_1_in = pin_in.a[5];
      if (m7 == 2'h1) s.ext_interrupt_5_in = pin_in.b[7];
      if (m7 == 2'h3) s.bus_request_in = pin_in.b[7];
      if (m8 == 2'h1) s.ext_interrupt_6_in = pin_in.b[8];
      if (m8 == 2'h3) s.bus_wait_in = pin_in.b[8];
      if (m9 == 2'h1) s.ext_interrupt_7_in = pin_in.b[9];
      if (m9 == 2'h3) s.converter_trigger_in = pin_in.b[9];
      `CHK(fn_sense, s)
      oa = port_a_dir;
      if (pa[0]) oa[0] = 1'b0;
      if (pa[2]) oa[1] = 1'b1;
      if (m2 != 2'h0) oa[2] = (m2 == 2'h1) & fn_drive.serial_clock_ch0_oe;
      if (pa[6]) oa[3] = 1'b0;
      if (pa[8]) oa[4] = 1'b1;
      if (m5 != 2'h0) oa[5] = (m5 == 2'h1) & fn_drive.serial_clock_ch1_oe;
      `CHK(pin_oe.a, oa)
      ob = dr[9:7];
      if (m7 != 2'h0) ob[0] = (m7 == 2'h2);
      if (m8 != 2'h0) ob[1] = (m8 == 2'h2);
      if (m9 != 2'h0) ob[2] = (m9 == 2'h2);
      `CHK(pin_oe.b[9:7], ob)
      if (!c2[0]) `CHK(pin_oe.b[0], dr[0])
      if (!pa[0] && port_a_dir[0]) `CHK(pin_out.a[0], port_a_data[0])
      if (pa[2]) `CHK(pin_out.a[1], fn_drive.serial_tx_ch0)
      if (pa[8]) `CHK(pin_out.a[4], fn_drive.serial_tx_ch1)
      if (m9 == 2'h2) `CHK(pin_out.b[9], fn_drive.addr_bit_21_out)
      if (m8 == 2'h2) `CHK(pin_out.b[8], fn_drive.addr_bit_20_out)
      if (m7 == 2'h2) `CHK(pin_out.b[7], fn_drive.addr_bit_19_out)
      if (m2 == 2'h1) `CHK(pin_out.a[2], fn_drive.serial_clock_ch0_out)
      if (m5 == 2'h1) `CHK(pin_out.a[5], fn_drive.serial_clock_ch1_out)
      if (m9 == 2'h0 && dr[9]) `CHK(pin_out.b[9], port_b_data[9])
      if (!c2[0] && dr[0]) `CHK(pin_out.b[0], port_b_data[0])
      `CHK(port_pin_val, pin_in)
   endtask
   task automatic end_of_test();
      if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      end_of_test();
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) apb(1'b0, 12'(i * 4), 16'h0, 32'h0, 1'b0);
      apb(1'b1, 12'h018, 16'hFFFF, 32'h0, 1'b1);
      apb(1'b0, 12'h018, 16'h0, 32'h0, 1'b1);
      // Ones into reserved bits must be dropped
      apb(1'b1, `PABFS_OFS_PB_DIR, 16'hFFFF, 32'h0, 1'b0);
      apb(1'b0, `PABFS_OFS_PB_DIR, 16'h0, 32'h0000_03FF, 1'b0);
      apb(1'b1, `PABFS_OFS_PB_CTRL1, 16'hFFFF, 32'h0, 1'b0);
      apb(1'b0, `PABFS_OFS_PB_CTRL1, 16'h0, 32'h0000_0C0F, 1'b0);
      apb(1'b1, `PABFS_OFS_PB_CTRL2, 16'hFFFF, 32'h0, 1'b0);
      apb(1'b0, `PABFS_OFS_PB_CTRL2, 16'h0, 32'h0000_FFF5, 1'b0);
      for (int i = 0; i < 48; i++) begin
         lf = lfsr(lf);
         // Writable fields only, so no reserved bit of pa is ever sent
         pa = lf[15:0] & `PABFS_WMASK_PA_LOW_CTRL2;
         dr = lf[31:16] & `PABFS_WMASK_PB_DIR;
         lf = lfsr(lfsr(lf));
         c1 = lf[15:0] & `PABFS_WMASK_PB_CTRL1;
         c2 = lf[31:16] & `PABFS_WMASK_PB_CTRL2;
         apb(1'b1, `PABFS_OFS_PA_LOW_CTRL2, pa, 32'h0, 1'b0);
         apb(1'b1, `PABFS_OFS_PB_DIR, dr, 32'h0, 1'b0);
         apb(1'b1, `PABFS_OFS_PB_CTRL1, c1, 32'h0, 1'b0);
         apb(1'b1, `PABFS_OFS_PB_CTRL2, c2, 32'h0, 1'b0);
         apb(1'b0, `PABFS_OFS_PA_LOW_CTRL2, 16'h0, {16'h0000, pa}, 1'b0);
         lf = lfsr(lf);
         pin_in <= lf[15:0];
         port_a_dir <= lf[21:16];
         port_a_data <= lf[27:22];
         lf = lfsr(lfsr(lf));
         port_b_data <= lf[9:0];
         fn_drive <= lf[18:10];
         repeat (3) @(posedge pclk);
         chk_pins();
         apb(1'b0, `PABFS_OFS_PIN_LEVEL, 16'h0, {16'h0000, pin_in}, 1'b0);
      end
      // Reset in mid-run clears the direction register
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `PABFS_OFS_PB_DIR, 16'h0, 32'h0, 1'b0);
      repeat (2) @(posedge pclk);
      end_of_test();
   end
endmodule // testbench
